//--- rtl/jtag_active_config_arbiter.sv
// Test-port instruction decoder arbitrating against the active serial loader.
// Assumes test pins and scheme pins are asynchronous to clock.
//
// Behaviour
// RL1: Test-port programming wins; an active serial load in progress is aborted.
// RL2: Disengage instruction idles the active controller during test-port programming.
// RL3: Host issues disengage before programming whenever an active scheme is selected.
// RL4: Disengage under passive serial or fast passive parallel is ignored entirely.
// RL5: I/O-configuration instruction is optional; halting never depends on it.
// RL6: Host keeps order: disengage, program, start-up, reset or other.
// RL7: Program, start-up and final reset are needed in every scheme and state.
// RL8: Host should check status between program and start-up.
// RL9: Host never issues I/O-configuration at power-up.
// RL10: Successful test-port start-up re-engages controller into its user-mode state.
// RL11: After failure, tap reset or engage instruction re-engages the controller.
// RL12: Serial memory clocked by configuration clock output, at most 40 MHz.
// RL13: Test-port loads are never decompressed.
// RL14: Select output low enables memory; commands out, data in on data line.
// RL15: One engaged flag: disengage clears; engage, reset, user mode set.
`timescale 1ns/1ps
`include "cfg_arb_params.svh"
module jtag_active_config_arbiter
  import cfg_arb_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       tck,
  input  wire logic       tms,
  input  wire logic       tdi,
  output logic            tdo,
  output logic            tdo_oe,
  input  wire logic [1:0] scheme_select_pins,
  input  wire logic       cfg_data_in,
  output logic            cfg_mem_select_n,
  output logic            cfg_clock_out,
  output logic            cfg_serial_out,
  output logic [7:0]      cfg_data_byte,
  output logic            engaged,
  output logic            jtag_user_mode,
  output logic            decompress_enable
);
  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  logic [4:0] sync1_reg, sync2_reg;
  logic       tck_d_reg;
  logic       tck_rise, tck_fall;

  // Every test pin and both scheme pins pass two flops. A third flop on the test clock finds
  // its edges, and its reset level matches the idle low level of that pin, so no false edge follows.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      tck_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {scheme_select_pins, tdi, tms, tck};
      sync2_reg <= sync1_reg;
      tck_d_reg <= sync2_reg[0];
    end
  end

  assign tck_rise = sync2_reg[0] && !tck_d_reg;
  assign tck_fall = !sync2_reg[0] && tck_d_reg;

  // Only the active schemes own an active controller that a disengage can idle.
  function automatic logic is_active_scheme(input logic [1:0] sel);
    is_active_scheme = (sel == `SCHEME_AS) || (sel == `SCHEME_AP);
  endfunction

  // ---------------------------------------------------------------------------
  // TAP controller and instruction register
  // ---------------------------------------------------------------------------
  tap_state_type             tap_reg, tap_next;
  logic [`IR_WIDTH-1:0]      irsh_reg, irsh_next;
  logic [`IR_WIDTH-1:0]      ir_reg, ir_next;
  logic                      byp_reg, byp_next;
  logic                      tdo_next, tdo_oe_next;
  logic                      tms_s, tdi_s;

  assign tms_s = sync2_reg[1];
  assign tdi_s = sync2_reg[2];

  // The test-port state machine moves only on a detected test-clock rise. Output data and its
  // enable change on the detected fall, so the host samples them settled at its next rise.
  always_comb begin
    tap_next    = tap_reg;
    irsh_next   = irsh_reg;
    ir_next     = ir_reg;
    byp_next    = byp_reg;
    tdo_next    = tdo;
    tdo_oe_next = tdo_oe;
    if (tck_rise) begin
      unique case (tap_reg)
        TAP_RESET:  tap_next = tms_s ? TAP_RESET  : TAP_IDLE;
        TAP_IDLE:   tap_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: tap_next = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: tap_next = tms_s ? TAP_EX1_DR : TAP_SH_DR;
        TAP_SH_DR:  tap_next = tms_s ? TAP_EX1_DR : TAP_SH_DR;
        TAP_EX1_DR: tap_next = tms_s ? TAP_UP_DR  : TAP_PA_DR;
        TAP_PA_DR:  tap_next = tms_s ? TAP_EX2_DR : TAP_PA_DR;
        TAP_EX2_DR: tap_next = tms_s ? TAP_UP_DR  : TAP_SH_DR;
        TAP_UP_DR:  tap_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR: tap_next = tms_s ? TAP_RESET  : TAP_CAP_IR;
        TAP_CAP_IR: tap_next = tms_s ? TAP_EX1_IR : TAP_SH_IR;
        TAP_SH_IR:  tap_next = tms_s ? TAP_EX1_IR : TAP_SH_IR;
        TAP_EX1_IR: tap_next = tms_s ? TAP_UP_IR  : TAP_PA_IR;
        TAP_PA_IR:  tap_next = tms_s ? TAP_EX2_IR : TAP_PA_IR;
        TAP_EX2_IR: tap_next = tms_s ? TAP_UP_IR  : TAP_SH_IR;
        TAP_UP_IR:  tap_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
      endcase
      if (tap_reg == TAP_CAP_IR) begin
        irsh_next = {{(`IR_WIDTH-2){1'b0}}, 2'h1};
      end else if (tap_reg == TAP_SH_IR) begin
        irsh_next = {tdi_s, irsh_reg[`IR_WIDTH-1:1]};
      end
      if (tap_reg == TAP_CAP_DR) begin
        byp_next = 1'b0;
      end else if (tap_reg == TAP_SH_DR) begin
        byp_next = tdi_s;
      end
      if (tap_reg == TAP_UP_IR) begin
        ir_next = irsh_reg;
      end else if (tap_reg == TAP_RESET) begin
        ir_next = `INSTR_BYPASS;
      end
    end
    if (tck_fall) begin
      tdo_oe_next = (tap_reg == TAP_SH_IR) || (tap_reg == TAP_SH_DR);
      tdo_next    = (tap_reg == TAP_SH_IR) ? irsh_reg[0] : byp_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Engage flag and programming progress
  // ---------------------------------------------------------------------------
  logic engaged_next, user_next, prog_reg, prog_next;
  logic instr_upd;

  // An instruction takes effect on the rise that leaves the update state.
  assign instr_upd = tck_rise && (tap_reg == TAP_UP_IR);

  // A disengage counts only under an active scheme; under a passive one it is dropped.
  // An engage abandons a failed load, so the reader is released at once. A test-clock rise in idle
  // with start-up loaded after a program is success and enters user mode.
  always_comb begin
    engaged_next = engaged;
    user_next    = jtag_user_mode;
    prog_next    = prog_reg;
    if (instr_upd) begin
      if (irsh_reg == `INSTR_DISENGAGE && is_active_scheme(sync2_reg[4:3])) begin
        engaged_next = 1'b0; // RL2 RL4 RL15
      end else if (irsh_reg == `INSTR_ENGAGE) begin
        engaged_next = 1'b1; // RL11 RL15
        prog_next    = 1'b0; // RL11
      end else if (irsh_reg == `INSTR_PROGRAM) begin
        prog_next = 1'b1;
        user_next = 1'b0;
      end
    end
    if (tck_rise && tap_reg == TAP_IDLE && ir_reg == `INSTR_STARTUP && prog_reg) begin
      user_next    = 1'b1;
      prog_next    = 1'b0;
      engaged_next = 1'b1; // RL10 RL15
    end
    // Every rise in the reset state re-engages and drops a pending load.
    if (tck_rise && tap_reg == TAP_RESET) begin
      engaged_next = 1'b1; // RL11 RL15
      prog_next    = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tap_reg           <= TAP_RESET;
      irsh_reg          <= {`IR_WIDTH{1'b0}};
      ir_reg            <= `INSTR_BYPASS;
      byp_reg           <= 1'b0;
      tdo               <= 1'b0;
      tdo_oe            <= 1'b0;
      engaged           <= 1'b1;
      jtag_user_mode    <= 1'b0;
      prog_reg          <= 1'b0;
      decompress_enable <= 1'b0;
    end else begin
      tap_reg           <= tap_next;
      irsh_reg          <= irsh_next;
      ir_reg            <= ir_next;
      byp_reg           <= byp_next;
      tdo               <= tdo_next;
      tdo_oe            <= tdo_oe_next;
      engaged           <= engaged_next;
      jtag_user_mode    <= user_next;
      prog_reg          <= prog_next;
      decompress_enable <= !prog_next && engaged_next; // RL13
    end
  end

  // ---------------------------------------------------------------------------
  // Active serial reader
  // ---------------------------------------------------------------------------
  arb_ctrl_if ctrl ();

  // The reader halts while disengaged or while a load is in progress. After a successful
  // load it stays in its user-mode state and does not read the memory again.
  always_comb begin
    ctrl.halt      = !engaged || prog_reg; // RL1 RL2
    ctrl.run       = engaged && !prog_reg && !jtag_user_mode && (sync2_reg[4:3] == `SCHEME_AS) && !ctrl.done; // RL10
    ctrl.user_mode = jtag_user_mode; // RL10
  end

  as_reader reader (
    .clock        (clock),
    .rst_b        (rst_b),
    .ctrl         (ctrl),
    .data_in      (cfg_data_in),
    .mem_select_n (cfg_mem_select_n),
    .cfg_clock    (cfg_clock_out),
    .serial_out   (cfg_serial_out),
    .data_byte    (cfg_data_byte)
  );
endmodule

//--- rtl/cfg_arb_params.svh
// Constants for the test-port and active configuration arbiter.
// Assumes inclusion by its bare name from rtl files.
`ifndef CFG_ARB_PARAMS_SVH
`define CFG_ARB_PARAMS_SVH
// -----------------------------------------------------------------------------
// Instruction codes (10-bit test-port instruction register)
// -----------------------------------------------------------------------------
`define IR_WIDTH            10
`define INSTR_DISENGAGE     10'h2D0
`define INSTR_ENGAGE        10'h2B0
`define INSTR_PROGRAM       10'h002
`define INSTR_STARTUP       10'h003
`define INSTR_CONFIG_IO     10'h00D
`define INSTR_BYPASS        10'h3FF
// -----------------------------------------------------------------------------
// Scheme-select encodings
// -----------------------------------------------------------------------------
`define SCHEME_PS           2'h0
`define SCHEME_FPP          2'h1
`define SCHEME_AS           2'h2
`define SCHEME_AP           2'h3
// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define SYS_CLK_MHZ         125
`define CFG_CLK_MAX_MHZ     40
`define CFG_CLK_HALF_CYC    ((`SYS_CLK_MHZ + 2 * `CFG_CLK_MAX_MHZ - 1) / (2 * `CFG_CLK_MAX_MHZ))
`define READ_CMD            8'h03
`define CMD_BITS            32
`define CFG_FRAME_BITS      16'h0400
`endif

//--- rtl/cfg_arb_pkg.sv
// Types for the test-port and active configuration arbiter.
// Assumes cfg_arb_params.svh is on the include path.
package cfg_arb_pkg;
  typedef enum logic [3:0] {
    TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR  = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR  = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UP_DR  = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR  = 4'hB,
    TAP_EX1_IR = 4'hC, TAP_PA_IR  = 4'hD, TAP_EX2_IR = 4'hE, TAP_UP_IR  = 4'hF
  } tap_state_type;

  typedef enum logic [2:0] {
    AS_IDLE    = 3'h0,
    AS_SELECT  = 3'h1,
    AS_COMMAND = 3'h2,
    AS_READ    = 3'h3,
    AS_USER    = 3'h4,
    AS_HALTED  = 3'h5
  } as_state_type;
endpackage

//--- rtl/arb_ctrl_if.sv
// Control bundle between the arbiter top and the serial reader.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/1ps
interface arb_ctrl_if;
  logic run;
  logic halt;
  logic user_mode;
  logic done;
  modport arbiter (output run, output halt, output user_mode, input done);
  modport reader  (input run, input halt, input user_mode, output done);
endinterface

//--- rtl/as_reader.sv
// Active serial configuration reader: selects memory and streams a frame.
// Assumes control from the arbiter on the same clock.
`timescale 1ns/1ps
`include "cfg_arb_params.svh"
module as_reader
  import cfg_arb_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   rst_b,
  arb_ctrl_if.reader  ctrl,
  input  wire logic   data_in,
  output logic        mem_select_n,
  output logic        cfg_clock,
  output logic        serial_out,
  output logic [7:0]  data_byte
);
  as_state_type state_reg, state_next;
  logic [7:0]  div_reg, div_next;
  logic        clk_reg, clk_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [31:0] sh_reg, sh_next;
  logic [7:0]  rx_reg, rx_next;
  logic        done_reg, done_next;
  logic        fall;

  assign fall = clk_reg && (div_reg == 8'(`CFG_CLK_HALF_CYC - 1));

  always_comb begin
    state_next = state_reg;
    div_next   = div_reg;
    clk_next   = clk_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    rx_next    = rx_reg;
    done_next  = done_reg;
    if (state_reg == AS_COMMAND || state_reg == AS_READ) begin
      if (div_reg == 8'(`CFG_CLK_HALF_CYC - 1)) begin
        div_next = 8'h00;
        clk_next = ~clk_reg; // RL12
      end else begin
        div_next = div_reg + 8'h01;
      end
    end else begin
      div_next = 8'h00;
      clk_next = 1'b0;
    end
    if (ctrl.halt) begin
      state_next = AS_HALTED;
    end else begin
      unique case (state_reg)
        AS_IDLE: begin
          if (ctrl.run) begin
            state_next = AS_SELECT;
            done_next  = 1'b0;
          end
        end
        AS_SELECT: begin
          sh_next    = {`READ_CMD, 24'h000000};
          cnt_next   = 16'h0000;
          state_next = AS_COMMAND;
        end
        AS_COMMAND: begin
          if (fall) begin
            sh_next  = {sh_reg[30:0], 1'b0};
            cnt_next = cnt_reg + 16'h0001;
            if (cnt_reg == 16'(`CMD_BITS - 1)) begin
              cnt_next   = 16'h0000;
              state_next = AS_READ;
            end
          end
        end
        AS_READ: begin
          if (clk_reg == 1'b0 && div_reg == 8'(`CFG_CLK_HALF_CYC - 1)) begin
            rx_next = {rx_reg[6:0], data_in}; // RL14
          end
          if (fall) begin
            cnt_next = cnt_reg + 16'h0001;
            if (cnt_reg == `CFG_FRAME_BITS - 16'h0001) begin
              done_next  = 1'b1;
              state_next = AS_USER;
            end
          end
        end
        AS_USER: begin
          if (ctrl.run) begin
            state_next = AS_SELECT;
          end
        end
        AS_HALTED: begin
          if (ctrl.user_mode) begin
            state_next = AS_USER; // RL10
          end else if (ctrl.run) begin
            state_next = AS_SELECT;
          end
        end
        default: state_next = AS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= AS_IDLE;
      div_reg      <= 8'h00;
      clk_reg      <= 1'b0;
      cnt_reg      <= 16'h0000;
      sh_reg       <= 32'h00000000;
      rx_reg       <= 8'h00;
      done_reg     <= 1'b0;
      mem_select_n <= 1'b1;
      cfg_clock    <= 1'b0;
      serial_out   <= 1'b0;
      data_byte    <= 8'h00;
    end else begin
      state_reg    <= state_next;
      div_reg      <= div_next;
      clk_reg      <= clk_next;
      cnt_reg      <= cnt_next;
      sh_reg       <= sh_next;
      rx_reg       <= rx_next;
      done_reg     <= done_next;
      mem_select_n <= !(state_next == AS_COMMAND || state_next == AS_READ); // RL14
      cfg_clock    <= clk_next;
      serial_out   <= sh_next[31];
      data_byte    <= rx_next;
    end
  end

  assign ctrl.done = done_reg;
endmodule

//--- verif/cfg_mem_model.sv
// Serial configuration memory seen from the arbiter's memory pins.
// Assumes the arbiter drives select, clock and command; the data line has a pull-up.
`timescale 1ns/1ps
module cfg_mem_model #(
  parameter logic [7:0] fill_byte = 8'hA5
) (
  input  wire logic cfg_mem_select_n,
  input  wire logic cfg_clock_out,
  input  wire logic cfg_serial_out,
  output logic      cfg_data_in
);
  int unsigned bit_count;
  logic [2:0]  idx;

  // ---------------------------------------------------------------------------
  // Bit counting and data return
  // ---------------------------------------------------------------------------
  always @(posedge cfg_clock_out or posedge cfg_mem_select_n) begin
    if (cfg_mem_select_n) begin
      bit_count <= 0;
    end else begin
      bit_count <= bit_count + 1;
    end
  end

  // Released or still taking the command, the pull-up holds the line high.
  always_comb begin
    idx = 3'(bit_count - 32);
    if (cfg_mem_select_n || bit_count < 32) begin
      cfg_data_in = 1'b1;
    end else begin
      cfg_data_in = fill_byte[3'h7 - idx];
    end
  end
endmodule

//--- verif/cfg_arb_props.sv
// Concurrent checks on the arbiter's top-level ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module cfg_arb_props (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic [1:0] scheme_select_pins,
  input wire logic       cfg_mem_select_n,
  input wire logic       cfg_clock_out,
  input wire logic       cfg_serial_out,
  input wire logic       engaged,
  input wire logic       jtag_user_mode,
  input wire logic       decompress_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_clk_high_min: assert property ($rose(cfg_clock_out) |=> cfg_clock_out || cfg_mem_select_n)
    else $error("config clock high phase too short");
  a_clk_low_min: assert property ($fell(cfg_clock_out) |=> !cfg_clock_out)
    else $error("config clock low phase too short");
  a_serial_hold: assert property (cfg_clock_out && $past(cfg_clock_out) |-> $stable(cfg_serial_out))
    else $error("serial out moved while config clock high");
  a_idle_clk_low: assert property (cfg_mem_select_n && $past(cfg_mem_select_n) |-> !cfg_clock_out)
    else $error("config clock runs with memory deselected");
  a_passive_ignore: assert property ($fell(engaged) |-> scheme_select_pins[1] && $past(scheme_select_pins[1], 4))
    else $error("controller disengaged under a passive scheme");
  a_halt_select: assert property ($fell(engaged) |-> ##[0:3] cfg_mem_select_n)
    else $error("memory still selected after disengage");
  a_idle_quiet: assert property (!engaged && !$past(engaged, 3) |-> cfg_mem_select_n)
    else $error("active controller busy while disengaged");
  a_no_decompress: assert property (!engaged && !$past(engaged) |-> !decompress_enable)
    else $error("decompression on while disengaged");
  a_user_engages: assert property ($rose(jtag_user_mode) |-> ##[0:2] engaged)
    else $error("user mode reached without re-engaging");
  a_user_quiet: assert property (jtag_user_mode && $past(jtag_user_mode, 3) |-> cfg_mem_select_n)
    else $error("memory read again after test-port load succeeded");

  c_disengage: cover property ($fell(engaged));
  c_user_mode: cover property ($rose(jtag_user_mode));
  c_mem_read: cover property ($fell(cfg_mem_select_n));
endmodule

bind jtag_active_config_arbiter cfg_arb_props props (
  .clock(clock), .rst_b(rst_b), .scheme_select_pins(scheme_select_pins),
  .cfg_mem_select_n(cfg_mem_select_n), .cfg_clock_out(cfg_clock_out), .cfg_serial_out(cfg_serial_out),
  .engaged(engaged), .jtag_user_mode(jtag_user_mode), .decompress_enable(decompress_enable)
);

//--- verif/jtag_active_config_arbiter_tb.sv
// Self-checking bench: acts as test-port host, memory model on the serial side.
// Assumes a test clock of 64 ns made here from the 8 ns system clock.
`timescale 1ns/1ps
`include "cfg_arb_params.svh"
module jtag_active_config_arbiter_tb;
  localparam logic [7:0] FILL_BYTE = 8'hA5;
  localparam logic [9:0] CHECK_STATUS_CODE = 10'h004;
  logic       clock = 1'b0;
  logic       rst_b = 1'b0;
  logic       tck = 1'b0;
  logic       tms = 1'b1;
  logic       tdi = 1'b0;
  logic [1:0] scheme_select_pins = `SCHEME_AS;
  logic       tdo, tdo_oe, cfg_data_in, cfg_mem_select_n, cfg_clock_out, cfg_serial_out;
  logic [7:0] cfg_data_byte;
  logic       engaged, jtag_user_mode, decompress_enable, last_tdo;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  always #4 clock = ~clock;

  jtag_active_config_arbiter DUT (
    .clock(clock), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .scheme_select_pins(scheme_select_pins), .cfg_data_in(cfg_data_in),
    .cfg_mem_select_n(cfg_mem_select_n), .cfg_clock_out(cfg_clock_out), .cfg_serial_out(cfg_serial_out),
    .cfg_data_byte(cfg_data_byte), .engaged(engaged), .jtag_user_mode(jtag_user_mode),
    .decompress_enable(decompress_enable)
  );

  cfg_mem_model #(.fill_byte(FILL_BYTE)) mem (
    .cfg_mem_select_n(cfg_mem_select_n), .cfg_clock_out(cfg_clock_out),
    .cfg_serial_out(cfg_serial_out), .cfg_data_in(cfg_data_in)
  );

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic conclude();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One test clock period: low five cycles, then high three; tms and tdi change at the fall.
  task automatic tap_step(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    repeat (5) @(posedge clock);
    last_tdo = tdo;
    tck <= 1'b1;
    repeat (3) @(posedge clock);
    tck <= 1'b0;
  endtask

  task automatic tap_reset();
    repeat (5) tap_step(1'b1, 1'b0);
    tap_step(1'b0, 1'b0);
  endtask

  // From Run-Test/Idle: shift a 10-bit instruction LSB first and return to idle.
  task automatic load_ir(input logic [9:0] code);
    logic [9:0] seen;
    logic       oe_all;
    oe_all = 1'b1;
    tap_step(1'b1, 1'b0);
    tap_step(1'b1, 1'b0);
    tap_step(1'b0, 1'b0);
    tap_step(1'b0, 1'b0);
    for (int i = 0; i < 10; i++) begin
      tap_step(i == 9, code[i]);
      seen[i] = last_tdo;
      oe_all = oe_all & tdo_oe;
    end
    tap_step(1'b1, 1'b0);
    tap_step(1'b0, 1'b0);
    repeat (4) @(posedge clock);
    check({20'h0, oe_all, tdo_oe, seen}, 32'h00000801);
  endtask

  task automatic cfg_rise();
    logic prev;
    prev = cfg_clock_out;
    for (int i = 0; i < 40; i++) begin
      @(negedge clock);
      if (!prev && cfg_clock_out) return;
      prev = cfg_clock_out;
    end
    check({31'h0, cfg_clock_out}, 32'h2);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset_values();
    check({31'h0, engaged}, 32'h1);
    check({29'h0, cfg_mem_select_n, jtag_user_mode, decompress_enable}, 32'h4);
  endtask

  task automatic t_as_read();
    logic [31:0] cmd;
    for (int i = 0; i < 200 && cfg_mem_select_n !== 1'b0; i++) @(negedge clock);
    check({31'h0, cfg_mem_select_n}, 32'h0);
    for (int i = 31; i >= 0; i--) begin
      cfg_rise();
      cmd[i] = cfg_serial_out;
    end
    check(cmd, {`READ_CMD, 24'h0});
    repeat (16) cfg_rise();
    @(negedge clock);
    check({24'h0, cfg_data_byte}, {24'h0, FILL_BYTE});
    @(posedge clock);
  endtask

  task automatic t_disengage_mid_read();
    load_ir(`INSTR_DISENGAGE);
    check({30'h0, engaged, decompress_enable}, 32'h0);
    check({31'h0, cfg_mem_select_n}, 32'h1);
    load_ir(`INSTR_CONFIG_IO);
    check({30'h0, engaged, cfg_mem_select_n}, 32'h1);
  endtask

  task automatic t_program_success();
    load_ir(`INSTR_PROGRAM);
    check({31'h0, cfg_mem_select_n}, 32'h1);
    check({31'h0, decompress_enable}, 32'h0);
    load_ir(CHECK_STATUS_CODE);
    check({30'h0, cfg_mem_select_n, jtag_user_mode}, 32'h2);
    load_ir(`INSTR_STARTUP);
    repeat (2) tap_step(1'b0, 1'b0);
    repeat (4) @(posedge clock);
    check({30'h0, jtag_user_mode, engaged}, 32'h3);
    repeat (8) @(posedge clock);
    check({31'h0, cfg_mem_select_n}, 32'h1);
  endtask

  task automatic t_passive_ignored();
    tap_reset();
    repeat (4) @(posedge clock);
    check({30'h0, jtag_user_mode, engaged}, 32'h3);
    scheme_select_pins <= `SCHEME_PS;
    repeat (8) @(posedge clock);
    load_ir(`INSTR_DISENGAGE);
    check({31'h0, engaged}, 32'h1);
    scheme_select_pins <= `SCHEME_FPP;
    repeat (8) @(posedge clock);
    load_ir(`INSTR_DISENGAGE);
    check({31'h0, engaged}, 32'h1);
    scheme_select_pins <= `SCHEME_AS;
    repeat (8) @(posedge clock);
  endtask

  task automatic t_failed_reengage(input logic by_reset);
    load_ir(`INSTR_DISENGAGE);
    check({31'h0, engaged}, 32'h0);
    load_ir(`INSTR_PROGRAM);
    if (by_reset) begin
      tap_reset();
      repeat (4) @(posedge clock);
    end else begin
      load_ir(`INSTR_ENGAGE);
    end
    check({30'h0, jtag_user_mode, engaged}, 32'h1);
    check({30'h0, cfg_mem_select_n, decompress_enable}, 32'h1);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and hang guard
  // ---------------------------------------------------------------------------
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(posedge clock);
    t_reset_values();
    rst_b <= 1'b1;
    t_as_read();
    tap_reset();
    t_disengage_mid_read();
    t_program_success();
    t_passive_ignored();
    t_failed_reengage(1'b0);
    t_failed_reengage(1'b1);
    conclude();
  end
endmodule
